// File: cic_pkg.sv
// Package of constants and carrier types for the CPU interface control register block
package cic_pkg;
  // ==========================================================================
  // Register map
  localparam logic [11:0] CIC_CTRL_OFFSET = 12'h000;
  localparam logic [11:0] CIC_BPR_OFFSET = 12'h008;
  localparam logic [11:0] CIC_ABPR_OFFSET = 12'h01c;
  // ==========================================================================
  // Secure view field positions
  localparam int CIC_S_SPLIT_NS = 10;
  localparam int CIC_S_SPLIT_S = 9;
  localparam int CIC_S_BNO_G1 = 8;
  localparam int CIC_S_BFO_G1 = 7;
  localparam int CIC_S_BNO_G0 = 6;
  localparam int CIC_S_BFO_G0 = 5;
  localparam int CIC_COMMON_BINARY_POINT_POS = 4;
  localparam int CIC_FAST_G0_POS = 3;
  localparam int CIC_S_EN_G1 = 1;
  localparam int CIC_S_EN_G0 = 0;
  // ==========================================================================
  // Non-secure view field positions
  localparam int CIC_NS_SPLIT = 9;
  localparam int CIC_NS_BNO_G1 = 6;
  localparam int CIC_NS_BFO_G1 = 5;
  localparam int CIC_NS_EN_G1 = 0;
  // ==========================================================================
  // Reset values and limits
  localparam logic [2:0] CIC_BP_RESET = 3'h0;
  localparam logic [2:0] CIC_BP_MAX = 3'h7;
  // ==========================================================================
  // Stored control state, one copy shared by all views
  typedef struct packed {
    logic split_ns;
    logic split_s;
    logic bno_g1;
    logic bfo_g1;
    logic bno_g0;
    logic bfo_g0;
    logic common_binary_point;
    logic fast_g0;
    logic en_g1;
    logic en_g0;
  } cic_ctrl_t;
  localparam cic_ctrl_t CIC_CTRL_RESET = '0;
  // Register bus request
  typedef struct packed {
    logic sel;
    logic wr;
    logic secure;
    logic [11:0] addr;
    logic [31:0] wdata;
  } cic_req_t;
endpackage : cic_pkg

// File: cic_view_map.sv
// Packs stored control state into the view selected for a read
`timescale 1ns/1ps
`default_nettype none
module cic_view_map
  import cic_pkg::*;
(
  input wire cic_ctrl_t ctrl_in,
  input wire logic single_in,
  input wire logic secure_in,
  output logic [31:0] view_out
);
  // ==========================================================================
  // View packing; unlisted bits stay zero
  logic [31:0] s_view;
  logic [31:0] ns_view;
  logic [31:0] ss_view;
  always_comb
  begin
    s_view = 32'h0;
    s_view[CIC_S_SPLIT_NS] = ctrl_in.split_ns; // [R6]
    s_view[CIC_S_SPLIT_S] = ctrl_in.split_s; // [R7]
    s_view[CIC_S_BNO_G1] = ctrl_in.bno_g1; // [R10]
    s_view[CIC_S_BFO_G1] = ctrl_in.bfo_g1; // [R11]
    s_view[CIC_S_BNO_G0] = ctrl_in.bno_g0;
    s_view[CIC_S_BFO_G0] = ctrl_in.bfo_g0;
    s_view[CIC_COMMON_BINARY_POINT_POS] = ctrl_in.common_binary_point; // [R12]
    s_view[CIC_FAST_G0_POS] = ctrl_in.fast_g0; // [R14]
    s_view[CIC_S_EN_G1] = ctrl_in.en_g1; // [R16]
    s_view[CIC_S_EN_G0] = ctrl_in.en_g0;
    ss_view = s_view;
    ss_view[CIC_S_SPLIT_NS] = 1'b0; // [R17]
    ns_view = 32'h0;
    ns_view[CIC_NS_SPLIT] = ctrl_in.split_ns; // [R20]
    ns_view[CIC_NS_BNO_G1] = ctrl_in.bno_g1;
    ns_view[CIC_NS_BFO_G1] = ctrl_in.bfo_g1; // [R1]
    ns_view[CIC_NS_EN_G1] = ctrl_in.en_g1; // [R2]
  end
  // Banked selection by access security
  assign view_out = single_in ? ss_view : (secure_in ? s_view : ns_view); // [R19]
endmodule : cic_view_map
`default_nettype wire

// File: cic_line_gate.sv
// Decides what reaches the processor's normal and fast interrupt lines
`timescale 1ns/1ps
`default_nettype none
module cic_line_gate
  import cic_pkg::*;
(
  input wire cic_ctrl_t ctrl_in,
  input wire logic sre_os_in,
  input wire logic pend_g0_in,
  input wire logic pend_g1_in,
  input wire logic bypass_normal_in,
  input wire logic bypass_fast_in,
  output logic normal_out,
  output logic fast_out
);
  // ==========================================================================
  // Group signals gated by their enables
  logic g0_sig;
  logic g1_sig;
  logic g0_fast;
  logic normal_on;
  logic fast_on;
  logic bp_normal;
  logic bp_fast;
  assign g0_sig = ctrl_in.en_g0 & pend_g0_in;
  assign g1_sig = ctrl_in.en_g1 & pend_g1_in;
  // Group 0 may move to the fast line; Group 1 never does
  assign g0_fast = ctrl_in.fast_g0; // [R14]
  assign normal_on = ctrl_in.en_g1 | (ctrl_in.en_g0 & ~g0_fast);
  assign fast_on = ctrl_in.en_g0 & g0_fast;
  // Bypass passes only while line signaling is off and both disables clear
  // System register access at the OS level blinds the disables entirely
  assign bp_normal = bypass_normal_in & ~normal_on &
                     (sre_os_in | ~(ctrl_in.bno_g0 | ctrl_in.bno_g1)); // [R10] [R4]
  assign bp_fast = bypass_fast_in & ~fast_on &
                   (sre_os_in | ~(ctrl_in.bfo_g0 | ctrl_in.bfo_g1)); // [R11] [R1] [R4]
  assign normal_out = g1_sig | (g0_sig & ~g0_fast) | bp_normal;
  assign fast_out = (g0_sig & g0_fast) | bp_fast;
endmodule : cic_line_gate
`default_nettype wire

// File: cic_ctrl_regs.sv
// Top: CPU interface control register in its banked views, with line drive
//
// Summary of operation
// (R1) Non-secure bit 5: Group 1 fast bypass off
// (R2) Non-secure bit 0 Group 1 enable; bits 4:1 zero
// (R3) Top-level bypass disable forces fields one, writes ignored
// (R4) OS-level sysreg access ignores bypass disable fields
// (R5) No legacy support: bypass disables may be hard one
// (R6) Secure bit 10: Non-secure split drop/deactivate
// (R7) Secure bit 9: Secure split drop/deactivate
// (R8) Split fields may be hard-wired to one
// (R9) Secure split and common split share storage
// (R10) Bits 8 and 6: normal bypass off per group
// (R11) Bits 7 and 5: fast bypass off per group
// (R12) Bit 4 common binary point selects preemption source
// (R13) Common point: Non-secure read Secure+1 saturated; writes ignored
// (R14) Bit 3 puts Group 0 on fast line
// (R15) Dual security: fast select may be hard one
// (R16) Secure bits 1,0 group enables; bit 2 zero
// (R17) Single view bit 9 common split; 31:10 zero
// (R18) All fields reset zero; Secure 31:11 zero
// (R19) Dual security banks views by access security
// (R20) Non-secure bit 9 split, bit 6 normal bypass
// (R21) Software reaches register at offset 0x0000
// (R22) Reserved bits zero; writes touch visible fields only
`timescale 1ns/1ps
`default_nettype none
module cic_ctrl_regs
  import cic_pkg::*;
#(
  parameter bit LEGACY_SUPPORT = 1'b1, // Zero hard-wires bypass disables to one
  parameter bit SPLIT_RAO = 1'b0, // One hard-wires split fields to one
  parameter bit FAST_G0_RAO = 1'b0 // One hard-wires fast select (dual security only)
)
(
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Register port from the processing element
  input wire logic reg_sel_in,
  input wire logic reg_wr_in,
  input wire logic reg_secure_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  output logic [31:0] reg_rdata_out,
  output logic reg_ack_out,
  // Configuration, same clock domain
  input wire logic single_security_select_in,
  input wire logic sre_top_in,
  input wire logic top_level_normal_bypass_disable_in,
  input wire logic top_level_fast_bypass_disable_in,
  input wire logic sre_os_in,
  // Pending group requests from the priority logic
  input wire logic pend_g0_in,
  input wire logic pend_g1_in,
  // Legacy bypass lines from pins
  input wire logic bypass_normal_in,
  input wire logic bypass_fast_in,
  // Processor lines
  output logic normal_irq_out,
  output logic fast_irq_out,
  // Split mode for the end-of-interrupt logic, common binary point select for preemption
  output logic split_ns_out,
  output logic split_s_out,
  output logic common_binary_point_out
);
  // ==========================================================================
  // Request carrier and decode
  cic_req_t req;
  assign req = '{sel: reg_sel_in, wr: reg_wr_in, secure: reg_secure_in,
                 addr: reg_addr_in, wdata: reg_wdata_in};
  logic hit_ctrl;
  logic hit_bpr;
  logic hit_abpr;
  logic wr_ctrl;
  logic sec_eff;
  assign hit_ctrl = req.sel & (req.addr == CIC_CTRL_OFFSET); // [R21]
  assign hit_bpr = req.sel & (req.addr == CIC_BPR_OFFSET);
  assign hit_abpr = req.sel & (req.addr == CIC_ABPR_OFFSET);
  assign wr_ctrl = hit_ctrl & req.wr;
  // Single security: every access sees the single view
  assign sec_eff = req.secure | single_security_select_in; // [R19]
  // ==========================================================================
  // Pin synchronisers: three flops, change taken when the last two agree
  logic [2:0] byp_n_sync_ff;
  logic [2:0] byp_f_sync_ff;
  logic byp_n_ff;
  logic byp_f_ff;
  logic nxt_byp_n;
  logic nxt_byp_f;
  // Shift chain; bit 0 may go metastable
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      byp_n_sync_ff <= 3'h0;
      byp_f_sync_ff <= 3'h0;
    end
    else
    begin
      byp_n_sync_ff <= {byp_n_sync_ff[1:0], bypass_normal_in};
      byp_f_sync_ff <= {byp_f_sync_ff[1:0], bypass_fast_in};
    end
  end
  // First stage is only read by the second
  assign nxt_byp_n = (byp_n_sync_ff[1] == byp_n_sync_ff[2]) ? byp_n_sync_ff[2] : byp_n_ff;
  assign nxt_byp_f = (byp_f_sync_ff[1] == byp_f_sync_ff[2]) ? byp_f_sync_ff[2] : byp_f_ff;
  // Filtered level; holds until the last two stages agree
  // A one-cycle pin glitch never reaches the lines
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      byp_n_ff <= 1'b0;
      byp_f_ff <= 1'b0;
    end
    else
    begin
      byp_n_ff <= nxt_byp_n;
      byp_f_ff <= nxt_byp_f;
    end
  end
  // ==========================================================================
  // Force-to-one terms for read-as-one fields
  // Hard-wired choices fold in here so every reader agrees
  logic force_bno;
  logic force_bfo;
  logic force_fast;
  assign force_bno = ~LEGACY_SUPPORT | (sre_top_in & top_level_normal_bypass_disable_in); // [R3] [R5]
  assign force_bfo = ~LEGACY_SUPPORT | (sre_top_in & top_level_fast_bypass_disable_in); // [R3] [R5]
  assign force_fast = FAST_G0_RAO & ~single_security_select_in; // [R15]
  // ==========================================================================
  // Stored fields and the effective (forced) copy
  cic_ctrl_t ctrl_ff;
  cic_ctrl_t nxt_ctrl;
  cic_ctrl_t ctrl_eff;
  always_comb
  begin
    ctrl_eff = ctrl_ff;
    ctrl_eff.bno_g0 = ctrl_ff.bno_g0 | force_bno;
    ctrl_eff.bno_g1 = ctrl_ff.bno_g1 | force_bno;
    ctrl_eff.bfo_g0 = ctrl_ff.bfo_g0 | force_bfo;
    ctrl_eff.bfo_g1 = ctrl_ff.bfo_g1 | force_bfo;
    ctrl_eff.split_ns = ctrl_ff.split_ns | SPLIT_RAO; // [R8]
    ctrl_eff.split_s = ctrl_ff.split_s | SPLIT_RAO; // [R8]
    ctrl_eff.fast_g0 = ctrl_ff.fast_g0 | force_fast;
  end
  // Write merge: each view updates only the fields it shows
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl && sec_eff)
    begin
      // Secure and single views share one layout below bit 10
      if (!single_security_select_in)
        nxt_ctrl.split_ns = req.wdata[CIC_S_SPLIT_NS]; // [R6]
      nxt_ctrl.split_s = req.wdata[CIC_S_SPLIT_S]; // [R7] [R9] [R17]
      // Forced fields keep their stored bit, shown again once released
      nxt_ctrl.bno_g1 = force_bno ? ctrl_ff.bno_g1 : req.wdata[CIC_S_BNO_G1]; // [R3] [R10]
      nxt_ctrl.bfo_g1 = force_bfo ? ctrl_ff.bfo_g1 : req.wdata[CIC_S_BFO_G1]; // [R3] [R11]
      nxt_ctrl.bno_g0 = force_bno ? ctrl_ff.bno_g0 : req.wdata[CIC_S_BNO_G0];
      nxt_ctrl.bfo_g0 = force_bfo ? ctrl_ff.bfo_g0 : req.wdata[CIC_S_BFO_G0];
      nxt_ctrl.common_binary_point = req.wdata[CIC_COMMON_BINARY_POINT_POS]; // [R12]
      nxt_ctrl.fast_g0 = force_fast ? ctrl_ff.fast_g0 : req.wdata[CIC_FAST_G0_POS]; // [R14]
      nxt_ctrl.en_g1 = req.wdata[CIC_S_EN_G1]; // [R16]
      nxt_ctrl.en_g0 = req.wdata[CIC_S_EN_G0];
    end
    else if (wr_ctrl)
    begin
      // Non-secure view reaches Group 1 fields only
      nxt_ctrl.split_ns = req.wdata[CIC_NS_SPLIT]; // [R20] [R22]
      nxt_ctrl.bno_g1 = force_bno ? ctrl_ff.bno_g1 : req.wdata[CIC_NS_BNO_G1]; // [R20]
      nxt_ctrl.bfo_g1 = force_bfo ? ctrl_ff.bfo_g1 : req.wdata[CIC_NS_BFO_G1]; // [R1]
      nxt_ctrl.en_g1 = req.wdata[CIC_NS_EN_G1]; // [R2]
    end
  end
  // Control storage; one copy serves every view
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
      ctrl_ff <= CIC_CTRL_RESET; // [R18]
    else
      ctrl_ff <= nxt_ctrl;
  end
  // ==========================================================================
  // Binary point registers, Secure and Non-secure copies
  // Non-secure copy also serves the alias register
  logic [2:0] bp_s_ff;
  logic [2:0] bp_ns_ff;
  logic [2:0] nxt_bp_s;
  logic [2:0] nxt_bp_ns;
  logic [2:0] bp_s_inc;
  logic dual_common_binary_point;
  assign dual_common_binary_point = ~single_security_select_in & ctrl_ff.common_binary_point;
  // Saturating increment of the Secure point
  assign bp_s_inc = (bp_s_ff == CIC_BP_MAX) ? CIC_BP_MAX : bp_s_ff + 3'h1; // [R13]
  // Secure writes own the Secure copy; Non-secure writes blocked in common mode
  assign nxt_bp_s = (hit_bpr && req.wr && sec_eff) ? req.wdata[2:0] : bp_s_ff;
  assign nxt_bp_ns = (hit_bpr && req.wr && !sec_eff && !dual_common_binary_point) ? req.wdata[2:0] : // [R13]
                     (hit_abpr && req.wr && sec_eff) ? req.wdata[2:0] : bp_ns_ff;
  // Point storage; zero reset is our choice, software must program it
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      bp_s_ff <= CIC_BP_RESET;
      bp_ns_ff <= CIC_BP_RESET;
    end
    else
    begin
      bp_s_ff <= nxt_bp_s;
      bp_ns_ff <= nxt_bp_ns;
    end
  end
  // ==========================================================================
  // Read path
  logic [31:0] ctrl_view;
  logic [31:0] nxt_rdata;
  logic [2:0] bpr_rd;
  cic_view_map u_view
  (
    .ctrl_in(ctrl_eff),
    .single_in(single_security_select_in),
    .secure_in(sec_eff),
    .view_out(ctrl_view)
  );
  assign bpr_rd = sec_eff ? bp_s_ff : (dual_common_binary_point ? bp_s_inc : bp_ns_ff); // [R13]
  // Unmapped or write accesses return zero
  // Alias point is Secure only; a Non-secure look reads zero
  assign nxt_rdata = (!req.sel || req.wr) ? 32'h0 :
                     hit_ctrl ? ctrl_view : // [R22]
                     hit_bpr ? {29'h0, bpr_rd} :
                     (hit_abpr && sec_eff) ? {29'h0, bp_ns_ff} : 32'h0;
  // Every request is answered one cycle later, unmapped ones too
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      reg_rdata_out <= 32'h0;
      reg_ack_out <= 1'b0;
    end
    else
    begin
      reg_rdata_out <= nxt_rdata;
      reg_ack_out <= req.sel;
    end
  end
  // ==========================================================================
  // Line drive, registered
  logic nxt_normal;
  logic nxt_fast;
  cic_line_gate u_gate
  (
    .ctrl_in(ctrl_eff),
    .sre_os_in(sre_os_in),
    .pend_g0_in(pend_g0_in),
    .pend_g1_in(pend_g1_in),
    .bypass_normal_in(byp_n_ff),
    .bypass_fast_in(byp_f_ff),
    .normal_out(nxt_normal),
    .fast_out(nxt_fast)
  );
  // Lines and field copies leave straight from flops
  // Costs a cycle of latency but keeps the lines glitch free
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      normal_irq_out <= 1'b0;
      fast_irq_out <= 1'b0;
      split_ns_out <= 1'b0;
      split_s_out <= 1'b0;
      common_binary_point_out <= 1'b0;
    end
    else
    begin
      normal_irq_out <= nxt_normal;
      fast_irq_out <= nxt_fast;
      split_ns_out <= ctrl_eff.split_ns; // [R6]
      split_s_out <= ctrl_eff.split_s; // [R7] [R9]
      common_binary_point_out <= ctrl_ff.common_binary_point; // [R12]
    end
  end
  // ==========================================================================
  // Assertions
  // Every check runs on the system clock and sleeps during reset
  a_ns_reserved_zero: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // [R2]
    $past(hit_ctrl & ~req.wr & ~sec_eff) |-> reg_rdata_out[4:1] == 4'h0)
    else $error("Non-secure reserved bits nonzero");
  a_ns_upper_zero: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // [R20]
    $past(hit_ctrl & ~req.wr & ~sec_eff) |-> reg_rdata_out[31:10] == 22'h0 &&
    reg_rdata_out[8:7] == 2'h0)
    else $error("Non-secure upper bits nonzero");
  a_s_upper_zero: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // [R18]
    $past(hit_ctrl & ~req.wr & sec_eff) |-> reg_rdata_out[31:11] == 21'h0 &&
    reg_rdata_out[2] == 1'b0)
    else $error("Secure reserved bits nonzero");
  a_single_bit_zero: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // [R17]
    $past(hit_ctrl & ~req.wr & single_security_select_in) |-> reg_rdata_out[10] == 1'b0)
    else $error("Single view bit 10 nonzero");
  a_ack_per_access: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // [R21]
    req.sel |=> reg_ack_out)
    else $error("Request left without acknowledge");
  a_force_bno_one: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // [R3]
    force_bno |-> ctrl_view[CIC_NS_BNO_G1] | (sec_eff & ctrl_view[CIC_S_BNO_G1]))
    else $error("Forced bypass disable reads zero");
  a_forced_write_keeps: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // [R3]
    (wr_ctrl & force_bno) |=> $stable(ctrl_ff.bno_g0) && $stable(ctrl_ff.bno_g1))
    else $error("Forced bypass disable took a write");
  a_split_shared: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // [R9]
    (wr_ctrl & sec_eff) |=> ##1
    split_s_out == ($past(req.wdata[CIC_S_SPLIT_S], 2) | SPLIT_RAO))
    else $error("Split field not shared");
  a_ns_write_keeps: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // [R22]
    (wr_ctrl & ~sec_eff) |=> $stable(ctrl_ff.en_g0) && $stable(ctrl_ff.common_binary_point))
    else $error("Non-secure write altered Secure field");
  a_bpr_sat_read: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // [R13]
    (hit_bpr & ~req.wr & ~sec_eff & dual_common_binary_point & bp_s_ff == CIC_BP_MAX) |=>
    reg_rdata_out == 32'h7)
    else $error("Binary point read not saturated");
  a_bpr_ns_ignored: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // [R13]
    (hit_bpr & req.wr & ~sec_eff & dual_common_binary_point & ~hit_abpr) |=> $stable(bp_ns_ff))
    else $error("Non-secure point write not ignored");
  // Line checks
  a_g1_not_fast: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // [R14]
    (~ctrl_eff.en_g0 & ~byp_f_ff) |=> ~fast_irq_out)
    else $error("Fast line raised without Group 0");
  a_g1_normal_line: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // [R14]
    (ctrl_eff.en_g1 & pend_g1_in) |=> normal_irq_out)
    else $error("Group 1 missing on normal line");
  a_g0_fast_line: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // [R14]
    (ctrl_eff.en_g0 & ctrl_eff.fast_g0 & pend_g0_in) |=> fast_irq_out)
    else $error("Group 0 missing on fast line");
  a_sre_os_bypass: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // [R4]
    (sre_os_in & byp_n_ff & ~ctrl_eff.en_g0 & ~ctrl_eff.en_g1) |=> normal_irq_out)
    else $error("Bypass blocked at OS-level access");
  // Cover points for the main scenarios
  c_secure_write: cover property (@(posedge clk_sys_in) disable iff (!rstn_in)
    wr_ctrl & sec_eff);
  c_ns_read: cover property (@(posedge clk_sys_in) disable iff (!rstn_in)
    hit_ctrl & ~req.wr & ~sec_eff);
  c_fast_line: cover property (@(posedge clk_sys_in) disable iff (!rstn_in) fast_irq_out);
  c_bypass_pass: cover property (@(posedge clk_sys_in) disable iff (!rstn_in)
    byp_n_ff & ~ctrl_eff.en_g1 & ~ctrl_eff.en_g0 ##1 normal_irq_out);
  c_single_write: cover property (@(posedge clk_sys_in) disable iff (!rstn_in)
    wr_ctrl & single_security_select_in);
endmodule : cic_ctrl_regs
`default_nettype wire

// File: cic_pe_model.sv
// Processor-side model that samples the normal and fast interrupt lines
`timescale 1ns/1ps
`default_nettype none
module cic_pe_model
(
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic normal_irq_in,
  input wire logic fast_irq_in,
  output logic normal_seen_out,
  output logic fast_seen_out
);
  // ======================================
  // Line sampling
  logic normal_ff; // Last level seen on the normal line
  logic fast_ff; // Last level seen on the fast line
  // Lines are levels; a core takes them on its clock, so one cycle late
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      normal_ff <= 1'b0;
      fast_ff <= 1'b0;
    end
    else
    begin
      normal_ff <= normal_irq_in;
      fast_ff <= fast_irq_in;
    end
  end
  assign normal_seen_out = normal_ff;
  assign fast_seen_out = fast_ff;
endmodule : cic_pe_model
`default_nettype wire

// File: cic_ctrl_regs_tb_top.sv
// Self-checking bench for the banked CPU interface control register
`timescale 1ns/1ps
`default_nettype none
module cic_ctrl_regs_tb_top
  import cic_pkg::*;
;
  // ======================================
  // Expected view masks
  localparam logic [31:0] S_MASK = 32'h000007fb; // Secure view, bit 2 reserved
  localparam logic [31:0] SG_MASK = 32'h000003fb; // Single view, no bit 10
  localparam logic [31:0] NS_MASK = 32'h00000261; // Non-secure view
  // ======================================
  // Stimulus and observation
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  cic_req_t req = '0; // Register request as one bundle
  logic single = 1'b0, sre_top = 1'b0, dib = 1'b0, dfb = 1'b0, sre_os = 1'b0;
  logic pg0 = 1'b0, pg1 = 1'b0, byn = 1'b0, byf = 1'b0;
  logic [31:0] rdata;
  logic ack, nirq, firq, spl_ns, spl_s, common_binary_point, seen_n, seen_f;
  logic [31:0] exp_q[$]; // One note per access, read or write
  logic [31:0] rng = 32'h0000000d;
  logic [31:0] wv;
  int err_total = 0;
  int checks_done = 0;
  // Clock, 8 ns period
  initial
  begin
    forever #4 clk_sys = ~clk_sys;
  end
  cic_ctrl_regs cic_ctrl_regs_i (.clk_sys_in(clk_sys), .rstn_in(rstn),
    .reg_sel_in(req.sel), .reg_wr_in(req.wr), .reg_secure_in(req.secure),
    .reg_addr_in(req.addr), .reg_wdata_in(req.wdata), .reg_rdata_out(rdata),
    .reg_ack_out(ack), .single_security_select_in(single), .sre_top_in(sre_top),
    .top_level_normal_bypass_disable_in(dib), .top_level_fast_bypass_disable_in(dfb),
    .sre_os_in(sre_os), .pend_g0_in(pg0), .pend_g1_in(pg1), .bypass_normal_in(byn),
    .bypass_fast_in(byf), .normal_irq_out(nirq), .fast_irq_out(firq),
    .split_ns_out(spl_ns), .split_s_out(spl_s), .common_binary_point_out(common_binary_point));
  cic_pe_model cic_pe_model_i (.clk_sys_in(clk_sys), .rstn_in(rstn), .normal_irq_in(nirq),
    .fast_irq_in(firq), .normal_seen_out(seen_n), .fast_seen_out(seen_f));
  // ======================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  // Non-secure layout derived from a Secure-layout value
  function automatic logic [31:0] ns_view(input logic [31:0] s);
    ns_view = 32'h0;
    ns_view[CIC_NS_SPLIT] = s[CIC_S_SPLIT_NS];
    ns_view[CIC_NS_BNO_G1] = s[CIC_S_BNO_G1];
    ns_view[CIC_NS_BFO_G1] = s[CIC_S_BFO_G1];
    ns_view[CIC_NS_EN_G1] = s[CIC_S_EN_G1];
  endfunction : ns_view
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One access; writes answer zero data
  task automatic acc(input logic w, input logic s, input logic [11:0] a,
    input logic [31:0] d, input logic [31:0] e);
    @(posedge clk_sys);
    req <= '{sel: 1'b1, wr: w, secure: s, addr: a, wdata: d};
    exp_q.push_back(w ? 32'h0 : e);
    @(posedge clk_sys);
    req.sel <= 1'b0;
  endtask : acc
  task automatic cw(input logic s, input logic [31:0] d);
    acc(1'b1, s, CIC_CTRL_OFFSET, d, 32'h0);
  endtask : cw
  task automatic rd(input logic s, input logic [11:0] a, input logic [31:0] e);
    acc(1'b0, s, a, 32'h0, e);
  endtask : rd
  // Lines settle through the pin synchroniser, then the model
  task automatic ln(input logic n, input logic f);
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("normal_line", {31'h0, n}, {31'h0, seen_n});
    chk("fast_line", {31'h0, f}, {31'h0, seen_f});
    // Hand back on a rising edge so the caller drives there
    @(posedge clk_sys);
  endtask : ln
  task automatic finish_test;
    if (err_total == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  // ======================================
  // Response watcher: every ack takes the oldest note
  always @(negedge clk_sys)
  begin
    if (ack === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("spare_ack", 32'h0, 32'h1);
      else
        chk("rdata", exp_q.pop_front(), rdata);
    end
  end
  // Watchdog, well beyond the expected run of a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    finish_test();
  end
  // ======================================
  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(1'b1, CIC_CTRL_OFFSET, 32'h0);
    rd(1'b0, CIC_CTRL_OFFSET, 32'h0);
    cw(1'b1, 32'hffffffff);
    rd(1'b1, CIC_CTRL_OFFSET, S_MASK);
    rd(1'b0, CIC_CTRL_OFFSET, NS_MASK);
    chk("split_common_binary_point", 32'h7, {29'h0, spl_ns, spl_s, common_binary_point});
    // Non-secure write must leave Secure-only fields alone
    cw(1'b0, 32'h0);
    rd(1'b1, CIC_CTRL_OFFSET, 32'h00000279);
    chk("split_ns", 32'h0, {31'h0, spl_ns});
    for (int i = 0; i < 8; i++)
    begin
      rng = xs(rng);
      wv = rng & S_MASK;
      cw(1'b1, rng);
      rd(1'b1, CIC_CTRL_OFFSET, wv);
      rd(1'b0, CIC_CTRL_OFFSET, ns_view(wv));
    end
    // Single view shares the split storage with the Secure view
    cw(1'b1, 32'h0);
    single <= 1'b1;
    cw(1'b1, 32'hffffffff);
    rd(1'b0, CIC_CTRL_OFFSET, SG_MASK);
    cw(1'b0, 32'h00000200);
    single <= 1'b0;
    rd(1'b1, CIC_CTRL_OFFSET, 32'h00000200);
    cw(1'b1, 32'h0);
    single <= 1'b1;
    rd(1'b1, CIC_CTRL_OFFSET, 32'h0);
    single <= 1'b0;
    // Line selection per group
    pg0 <= 1'b1;
    ln(1'b0, 1'b0);
    cw(1'b1, 32'h00000001);
    ln(1'b1, 1'b0);
    cw(1'b1, 32'h00000009);
    ln(1'b0, 1'b1);
    pg0 <= 1'b0;
    pg1 <= 1'b1;
    cw(1'b1, 32'h0000000a);
    ln(1'b1, 1'b0);
    pg1 <= 1'b0;
    // Legacy bypass with signaling off, then with Group 1 enabled
    byn <= 1'b1;
    byf <= 1'b1;
    cw(1'b1, 32'h0);
    ln(1'b1, 1'b1);
    cw(1'b1, 32'h00000100);
    ln(1'b0, 1'b1);
    sre_os <= 1'b1;
    ln(1'b1, 1'b1);
    sre_os <= 1'b0;
    cw(1'b1, 32'h00000020);
    ln(1'b1, 1'b0);
    cw(1'b1, 32'h0);
    cw(1'b0, 32'h00000020);
    ln(1'b1, 1'b0);
    cw(1'b0, 32'h00000040);
    ln(1'b0, 1'b1);
    cw(1'b1, 32'h00000002);
    ln(1'b0, 1'b1);
    // Top-level disables force the bypass fields to one
    sre_top <= 1'b1;
    dib <= 1'b1;
    dfb <= 1'b1;
    cw(1'b1, 32'h0);
    rd(1'b1, CIC_CTRL_OFFSET, 32'h000001e0);
    rd(1'b0, CIC_CTRL_OFFSET, 32'h00000060);
    sre_top <= 1'b0;
    // Common binary point: Non-secure sees Secure plus one, saturated
    cw(1'b1, 32'h00000010);
    acc(1'b1, 1'b1, CIC_BPR_OFFSET, 32'h00000005, 32'h0);
    rd(1'b0, CIC_BPR_OFFSET, 32'h00000006);
    acc(1'b1, 1'b1, CIC_BPR_OFFSET, 32'h00000007, 32'h0);
    rd(1'b0, CIC_BPR_OFFSET, 32'h00000007);
    acc(1'b1, 1'b0, CIC_BPR_OFFSET, 32'h00000002, 32'h0);
    rd(1'b1, CIC_BPR_OFFSET, 32'h00000007);
    rd(1'b1, CIC_ABPR_OFFSET, 32'h0);
    chk("common_binary_point", 32'h1, {31'h0, common_binary_point});
    // Mid-run reset clears every field
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    chk("common_binary_point_reset", 32'h0, {31'h0, common_binary_point});
    rd(1'b1, CIC_CTRL_OFFSET, 32'h0);
    // Unmapped and refused places read zero
    rd(1'b1, 12'h004, 32'h0);
    rd(1'b0, CIC_ABPR_OFFSET, 32'h0);
    repeat (4) @(posedge clk_sys);
    chk("notes_left", 32'h0, exp_q.size());
    finish_test();
  end
endmodule : cic_ctrl_regs_tb_top
`default_nettype wire
